// File: inc/ccr_defines.svh
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH
// ----------------------------------------------------------------
// Attribute register offsets
// ----------------------------------------------------------------
`define CCR_OFS_OPTION 11'h200
`define CCR_OFS_STATUS 11'h202
`define CCR_OFS_PINREP 11'h204
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CCR_OPT_SOFT_CARD_RESET 7
`define CCR_OPT_LEVIRQ 6
`define CCR_STS_CHANGED 7
`define CCR_STS_STATUS_CHANGE_ENABLE 6
`define CCR_STS_IO8 5
`define CCR_STS_PWD 2
`define CCR_STS_IRQ 1
`define CCR_PIN_CRDY 5
`define CCR_PIN_RRDY 1
`define CCR_RST_OPTION 8'h00
`define CCR_RST_STATUS 8'h00
`define CCR_RST_PINREP 8'h0c
`define CCR_PIN_FIXED 8'h0c
`define CCR_UNMAPPED 8'h00
// ----------------------------------------------------------------
// Mode index values and task-file windows
// ----------------------------------------------------------------
`define CCR_MODE_MEM 6'h00
`define CCR_MODE_CONTIG 6'h01
`define CCR_MODE_PRIMARY 6'h02
`define CCR_MODE_SECOND 6'h03
`define CCR_MEM_LO_END 11'h00f
`define CCR_MEM_HI_BEG 11'h400
`define CCR_MEM_HI_END 11'h7ff
`define CCR_PRI_BEG 11'h1f0
`define CCR_PRI_END 11'h1f7
`define CCR_PRI_ALT_BEG 11'h3f6
`define CCR_PRI_ALT_END 11'h3f7
`define CCR_SEC_BEG 11'h170
`define CCR_SEC_END 11'h177
`define CCR_SEC_ALT_BEG 11'h376
`define CCR_SEC_ALT_END 11'h377
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CCR_CLK_NS 50
`define CCR_IRQ_PULSE_NS 500
`define CCR_IRQ_PULSE_CYC ((`CCR_IRQ_PULSE_NS + `CCR_CLK_NS - 1) / `CCR_CLK_NS)
`define CCR_IDLE_CYC 1000
`endif

// File: inc/ccr_pkg.sv
package ccr_pkg;
   // Card operating mode index
   typedef logic [5:0] ccr_mode_t;
   // Power manager states
   typedef enum logic [1:0] {
      PWR_ACTIVE,
      PWR_ENTERING,
      PWR_ASLEEP,
      PWR_WAKING
   } ccr_pwr_e;
endpackage : ccr_pkg

// File: rtl/ccr_tf_decode.sv
`timescale 1ns/1ps
`include "ccr_defines.svh"
// Registered task-file address decoder for the current mode index
module ccr_tf_decode (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire ccr_pkg::ccr_mode_t mode,
   input wire logic mem_sel,
   input wire logic io_sel,
   input wire logic [10:0] addr,
   output logic hit_q
);
   logic hit_d;

   // ----------------------------------------------------------------
   // Window compare per mode
   // ----------------------------------------------------------------
   always_comb begin
      hit_d = 1'b0;
      case (mode)
         `CCR_MODE_MEM: begin
            hit_d = mem_sel && (addr <= `CCR_MEM_LO_END ||
               (addr >= `CCR_MEM_HI_BEG && addr <= `CCR_MEM_HI_END)); // [RQ7]
         end
         `CCR_MODE_CONTIG: begin
            hit_d = io_sel; // Host window picks base, nibble 0..F [RQ7]
         end
         `CCR_MODE_PRIMARY: begin
            hit_d = io_sel && ((addr >= `CCR_PRI_BEG && addr <= `CCR_PRI_END)
               || (addr >= `CCR_PRI_ALT_BEG
               && addr <= `CCR_PRI_ALT_END)); // [RQ8]
         end
         `CCR_MODE_SECOND: begin
            hit_d = io_sel && ((addr >= `CCR_SEC_BEG && addr <= `CCR_SEC_END)
               || (addr >= `CCR_SEC_ALT_BEG
               && addr <= `CCR_SEC_ALT_END)); // [RQ9]
         end
         default: begin
            hit_d = 1'b0; // Undefined indexes decode nothing
         end
      endcase
   end

   // Registered so the hit leaves on a flip-flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hit_q <= 1'b0;
      end else if (en) begin
         hit_q <= hit_d;
      end
   end

   chk_primary_window: assert property (@(posedge clk) disable iff (!rst_n)
      en && io_sel && mode == `CCR_MODE_PRIMARY && addr == 11'h1f7
      |=> hit_q) else $error("primary window missed"); // [RQ8]
   chk_secondary_miss: assert property (@(posedge clk) disable iff (!rst_n)
      en && mode == `CCR_MODE_SECOND && addr == 11'h1f7
      |=> !hit_q) else $error("secondary hit on primary"); // [RQ9]
endmodule : ccr_tf_decode

// File: rtl/ccr_power_mgr.sv
`timescale 1ns/1ps
`include "ccr_defines.svh"
// Sleep control: host request plus automatic idle sleep
module ccr_power_mgr #(
   parameter int IDLE_CYCLES = `CCR_IDLE_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic card_rst,
   input wire logic pwd_req,
   input wire logic core_idle,
   input wire logic core_cmd,
   input wire logic core_asleep,
   output logic sleep_req_q,
   output logic busy_q
);
   ccr_pkg::ccr_pwr_e st_q;
   logic pwd_prev_q;
   logic auto_q;
   logic [15:0] idle_cnt_q;
   logic want_sleep;

   assign want_sleep = pwd_req || auto_q;

   // Idle timer: auto sleep after a quiet spell, any command wakes [RQ15]
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt_q <= 16'h0000;
         auto_q <= 1'b0;
      end else if (en) begin
         if (card_rst || core_cmd || !core_idle) begin
            idle_cnt_q <= 16'h0000;
            auto_q <= 1'b0; // [RQ15]
         end else if (idle_cnt_q == 16'(IDLE_CYCLES - 1)) begin
            auto_q <= 1'b1; // [RQ15]
         end else begin
            idle_cnt_q <= idle_cnt_q + 16'h0001;
         end
      end
   end

   // Power state sequencing, done only when core confirms
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ccr_pkg::PWR_ACTIVE;
      end else if (en) begin
         case (st_q)
            ccr_pkg::PWR_ACTIVE: begin
               if (want_sleep) st_q <= ccr_pkg::PWR_ENTERING; // [RQ13]
            end
            ccr_pkg::PWR_ENTERING: begin
               if (!want_sleep) st_q <= ccr_pkg::PWR_WAKING;
               else if (core_asleep) st_q <= ccr_pkg::PWR_ASLEEP;
            end
            ccr_pkg::PWR_ASLEEP: begin
               if (!want_sleep) st_q <= ccr_pkg::PWR_WAKING; // [RQ13]
            end
            ccr_pkg::PWR_WAKING: begin
               if (want_sleep) st_q <= ccr_pkg::PWR_ENTERING;
               else if (!core_asleep) st_q <= ccr_pkg::PWR_ACTIVE;
            end
            default: begin
               st_q <= ccr_pkg::PWR_ACTIVE;
            end
         endcase
      end
   end

   // Sleep request to the core follows the host or idle request, held off in card reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_req_q <= 1'b0;
      end else if (en) begin
         sleep_req_q <= want_sleep && !card_rst; // [RQ13]
      end
   end

   // Busy from a host change until the core has reached it; set wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwd_prev_q <= 1'b0;
         busy_q <= 1'b0;
      end else if (en) begin
         pwd_prev_q <= pwd_req;
         if (pwd_req != pwd_prev_q) begin
            busy_q <= 1'b1; // [RQ14]
         end else if (core_asleep == pwd_req) begin
            busy_q <= 1'b0; // [RQ14]
         end
      end
   end

   chk_busy_on_change: assert property (@(posedge clk) disable iff (!rst_n)
      en && pwd_req != pwd_prev_q |=> busy_q)
      else $error("no busy after power change"); // [RQ14]
   chk_busy_until_done: assert property (@(posedge clk) disable iff (!rst_n)
      busy_q && core_asleep != pwd_req |=> busy_q)
      else $error("ready before power state reached"); // [RQ14]
   cov_asleep: cover property (@(posedge clk) disable iff (!rst_n)
      st_q == ccr_pkg::PWR_ASLEEP);
endmodule : ccr_power_mgr

// File: rtl/ccr_card_config.sv
`timescale 1ns/1ps
`include "ccr_defines.svh"
// ----------------------------------------------------------------
// Behaviour
// RQ1: Registers reachable in memory/I/O mode, not IDE
// RQ2: Soft reset bit holds card reset until cleared
// RQ3: Hard reset clears configuration, restarts initialisation
// RQ4: Level select bit picks pulse or level interrupts
// RQ5: Six-bit index picks memory or I/O mapping
// RQ6: Index returns zero on any reset
// RQ7: Memory and contiguous task-file windows decoded
// RQ8: Primary I/O window 1F0-1F7, 3F6-3F7
// RQ9: Secondary I/O window 170-177, 376-377
// RQ10: Changed bit drives status-change pin low
// RQ11: Enable bit zero keeps status-change pin high
// RQ12: Host sets 8-bit-only bit when needed
// RQ13: Power-down bit sleeps; clearing it wakes
// RQ14: Ready bit busy until power state reached
// RQ15: Auto sleep when idle, wake on command
// RQ16: Pending bit mirrors internal interrupt until serviced
// RQ17: Pending bit reads zero while interrupts masked
// RQ18: Ready change latch sets on ready transitions
// RQ19: Ready bit read returns ready pin level
// RQ20: Ready bit write masks latch update
// RQ21: IDE mode only with output enable grounded
// RQ22: Writes to read-only or fixed bits ignored
// ----------------------------------------------------------------
module ccr_card_config #(
   parameter int IDLE_CYCLES = `CCR_IDLE_CYC,
   parameter int PULSE_CYCLES = `CCR_IRQ_PULSE_CYC
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic CLK_EN,
   input wire logic HARD_RESET,
   input wire logic HOST_REG_N,
   input wire logic HOST_CE1_N,
   input wire logic HOST_OE_N,
   input wire logic HOST_WE_N,
   input wire logic HOST_IO_SEL,
   input wire logic [10:0] HOST_ADDR,
   input wire logic [7:0] HOST_DIN,
   output logic [7:0] HOST_DOUT,
   output logic HOST_DOE,
   input wire logic CORE_IRQ,
   input wire logic CORE_IRQ_MASK,
   input wire logic CORE_READY,
   input wire logic CORE_IDLE,
   input wire logic CORE_CMD,
   input wire logic CORE_ASLEEP,
   output logic CARD_RESET,
   output logic TRUE_IDE,
   output ccr_pkg::ccr_mode_t MODE_INDEX,
   output logic LEVEL_IRQ,
   output logic IO_8BIT,
   output logic SLEEP_REQ,
   output logic TF_HIT,
   output logic READY_PIN,
   output logic STATUS_CHANGE_PIN_N,
   output logic INTERRUPT_REQUEST_N
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic soft_card_reset_q;
   logic level_irq_select_q;
   ccr_pkg::ccr_mode_t mode_q;
   logic status_change_enable_q;
   logic io_8bit_only_q;
   logic power_down_request_q;
   logic ready_change_latch_q;
   logic ready_prev_q;
   logic strap_done_q;
   logic true_ide_q;
   logic we_prev_q;
   logic irq_prev_q;
   logic [7:0] pulse_cnt_q;
   logic attr_sel;
   logic wr_stb;
   logic rd_act;
   logic io_mode;
   logic irq_pending;
   logic pm_busy;
   logic pm_sleep;
   logic ready_pin_state;
   logic [7:0] rd_d;

   // Attribute space is closed in IDE mode [RQ1]
   assign attr_sel = !HOST_REG_N && !HOST_CE1_N && !true_ide_q; // [RQ1]
   assign wr_stb = attr_sel && !HOST_WE_N && we_prev_q;
   assign rd_act = attr_sel && !HOST_OE_N && HOST_WE_N;
   assign io_mode = (mode_q != `CCR_MODE_MEM);
   // Mask forces pending low, otherwise live request [RQ16] [RQ17]
   assign irq_pending = CORE_IRQ && !CORE_IRQ_MASK;
   assign ready_pin_state = CORE_READY && !pm_busy && !CARD_RESET; // [RQ14]

   // ----------------------------------------------------------------
   // Mode strap and write edge detect
   // ----------------------------------------------------------------
   // Output enable is sampled once after reset release, not at reset
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         strap_done_q <= 1'b0;
         true_ide_q <= 1'b0;
      end else if (CLK_EN && !strap_done_q) begin
         strap_done_q <= 1'b1;
         true_ide_q <= !HOST_OE_N; // [RQ21]
      end
   end

   // Write taken once, on the falling edge of write enable
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         we_prev_q <= 1'b1;
      end else if (CLK_EN) begin
         we_prev_q <= HOST_WE_N;
      end
   end

   // ----------------------------------------------------------------
   // Option register
   // ----------------------------------------------------------------
   // Hard reset wipes all; soft reset keeps its own bit set
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         soft_card_reset_q <= 1'(`CCR_RST_OPTION >> `CCR_OPT_SOFT_CARD_RESET);
         level_irq_select_q <= 1'b0;
         mode_q <= `CCR_MODE_MEM;
      end else if (CLK_EN) begin
         if (HARD_RESET) begin
            soft_card_reset_q <= 1'b0; // [RQ2] [RQ3]
            level_irq_select_q <= 1'b0; // [RQ3]
            mode_q <= `CCR_MODE_MEM; // [RQ6]
         end else if (wr_stb && HOST_ADDR == `CCR_OFS_OPTION) begin
            soft_card_reset_q <= HOST_DIN[`CCR_OPT_SOFT_CARD_RESET]; // [RQ2]
            level_irq_select_q <= HOST_DIN[`CCR_OPT_LEVIRQ]; // [RQ4]
            // Index stays zero while soft reset is written [RQ6]
            mode_q <= HOST_DIN[`CCR_OPT_SOFT_CARD_RESET] ? `CCR_MODE_MEM
               : HOST_DIN[5:0]; // [RQ5]
         end else if (soft_card_reset_q) begin
            mode_q <= `CCR_MODE_MEM; // [RQ6]
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration and status register
   // ----------------------------------------------------------------
   // Only enable, 8-bit and power-down are host bits [RQ22]
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         status_change_enable_q <= 1'b0;
         io_8bit_only_q <= 1'b0;
         power_down_request_q <= 1'b0;
      end else if (CLK_EN) begin
         if (CARD_RESET) begin
            status_change_enable_q <= 1'b0; // [RQ3]
            io_8bit_only_q <= 1'b0; // [RQ3]
            power_down_request_q <= 1'b0; // [RQ3]
         end else if (wr_stb && HOST_ADDR == `CCR_OFS_STATUS) begin
            status_change_enable_q <= HOST_DIN[`CCR_STS_STATUS_CHANGE_ENABLE]; // [RQ11]
            io_8bit_only_q <= HOST_DIN[`CCR_STS_IO8]; // [RQ12]
            power_down_request_q <= HOST_DIN[`CCR_STS_PWD]; // [RQ13]
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin replacement register
   // ----------------------------------------------------------------
   // A ready transition always wins over a host clear in that cycle
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         ready_prev_q <= 1'b0;
         ready_change_latch_q <= 1'b0;
      end else if (CLK_EN) begin
         ready_prev_q <= ready_pin_state;
         if (ready_pin_state != ready_prev_q) begin
            ready_change_latch_q <= 1'b1; // [RQ18]
         end else if (CARD_RESET) begin
            ready_change_latch_q <= 1'b0; // [RQ3]
         end else if (wr_stb && HOST_ADDR == `CCR_OFS_PINREP
               && HOST_DIN[`CCR_PIN_RRDY]) begin
            // Written ready bit is a mask, pin is untouched [RQ20]
            ready_change_latch_q <= HOST_DIN[`CCR_PIN_CRDY]; // [RQ18]
         end
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Unmapped attribute bytes read as zero; fixed bits as printed
   always_comb begin
      rd_d = `CCR_UNMAPPED;
      case (HOST_ADDR)
         `CCR_OFS_OPTION: begin
            rd_d = {soft_card_reset_q, level_irq_select_q, mode_q};
         end
         `CCR_OFS_STATUS: begin
            rd_d = `CCR_RST_STATUS;
            rd_d[`CCR_STS_CHANGED] = ready_change_latch_q; // [RQ10]
            rd_d[`CCR_STS_STATUS_CHANGE_ENABLE] = status_change_enable_q;
            rd_d[`CCR_STS_IO8] = io_8bit_only_q;
            rd_d[`CCR_STS_PWD] = power_down_request_q;
            rd_d[`CCR_STS_IRQ] = irq_pending; // [RQ16] [RQ17]
         end
         `CCR_OFS_PINREP: begin
            rd_d = `CCR_PIN_FIXED; // [RQ22]
            rd_d[`CCR_PIN_CRDY] = ready_change_latch_q;
            rd_d[`CCR_PIN_RRDY] = READY_PIN; // [RQ19]
         end
         default: begin
            rd_d = `CCR_UNMAPPED;
         end
      endcase
   end

   // Data and its enable leave on flops, one cycle behind the strobe
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         HOST_DOUT <= 8'h00;
         HOST_DOE <= 1'b0;
      end else if (CLK_EN) begin
         HOST_DOE <= rd_act; // [RQ1]
         HOST_DOUT <= rd_act ? rd_d : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Pins toward host and core
   // ----------------------------------------------------------------
   // Status change only acts in I/O configurations
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         STATUS_CHANGE_PIN_N <= 1'b1;
         READY_PIN <= 1'b0;
         CARD_RESET <= 1'b0;
      end else if (CLK_EN) begin
         STATUS_CHANGE_PIN_N <= !(ready_change_latch_q
            && status_change_enable_q && io_mode); // [RQ10] [RQ11]
         READY_PIN <= ready_pin_state; // [RQ19]
         CARD_RESET <= HARD_RESET || soft_card_reset_q; // [RQ2] [RQ3]
      end
   end

   // Config mirrors for the core
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         MODE_INDEX <= `CCR_MODE_MEM;
         LEVEL_IRQ <= 1'b0;
         IO_8BIT <= 1'b0;
         TRUE_IDE <= 1'b0;
         SLEEP_REQ <= 1'b0;
      end else if (CLK_EN) begin
         MODE_INDEX <= mode_q; // [RQ5]
         LEVEL_IRQ <= level_irq_select_q;
         IO_8BIT <= io_8bit_only_q;
         TRUE_IDE <= true_ide_q;
         SLEEP_REQ <= pm_sleep;
      end
   end

   // Pulse mode gives a fixed low pulse per new request; the host
   // may miss a second request raised inside one pulse
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         irq_prev_q <= 1'b0;
         pulse_cnt_q <= 8'h00;
         INTERRUPT_REQUEST_N <= 1'b1;
      end else if (CLK_EN) begin
         irq_prev_q <= irq_pending;
         if (irq_pending && !irq_prev_q) begin
            pulse_cnt_q <= 8'(PULSE_CYCLES);
         end else if (pulse_cnt_q != 8'h00) begin
            pulse_cnt_q <= pulse_cnt_q - 8'h01;
         end
         if (!io_mode) begin
            INTERRUPT_REQUEST_N <= 1'b1;
         end else if (level_irq_select_q) begin
            INTERRUPT_REQUEST_N <= !irq_pending; // [RQ4]
         end else begin
            INTERRUPT_REQUEST_N <= !(irq_pending && !irq_prev_q)
               && pulse_cnt_q <= 8'h01; // [RQ4]
         end
      end
   end

   // ----------------------------------------------------------------
   // Sub blocks
   // ----------------------------------------------------------------
   ccr_power_mgr #(.IDLE_CYCLES(IDLE_CYCLES)) u_power (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .en(CLK_EN),
      .card_rst(CARD_RESET),
      .pwd_req(power_down_request_q),
      .core_idle(CORE_IDLE),
      .core_cmd(CORE_CMD),
      .core_asleep(CORE_ASLEEP),
      .sleep_req_q(pm_sleep),
      .busy_q(pm_busy)
   );

   ccr_tf_decode u_decode (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .en(CLK_EN),
      .mode(mode_q),
      .mem_sel(HOST_REG_N && !HOST_CE1_N && !HOST_IO_SEL),
      .io_sel(!HOST_CE1_N && HOST_IO_SEL),
      .addr(HOST_ADDR),
      .hit_q(TF_HIT)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   chk_ide_no_attr: assert property (true_ide_q && CLK_EN |=> !HOST_DOE)
      else $error("attribute read answered in IDE mode"); // [RQ1]
   chk_soft_reset_hold: assert property (
      soft_card_reset_q && CLK_EN |=> CARD_RESET && MODE_INDEX == 6'h00)
      else $error("soft reset not holding card"); // [RQ2]
   chk_hard_reset_clear: assert property (HARD_RESET && CLK_EN
      |=> !soft_card_reset_q && mode_q == 6'h00 && !level_irq_select_q)
      else $error("hard reset left configuration"); // [RQ3]
   chk_mode_write: assert property (wr_stb && CLK_EN && !HARD_RESET
      && HOST_ADDR == 11'h200 && !HOST_DIN[7]
      |=> mode_q == $past(HOST_DIN[5:0]))
      else $error("mode index write lost"); // [RQ5]
   chk_status_change_pin_n_low: assert property (ready_change_latch_q
      && status_change_enable_q && io_mode && CLK_EN
      |=> !STATUS_CHANGE_PIN_N) else $error("status pin not low"); // [RQ10]
   chk_status_change_pin_n_gate: assert property (!status_change_enable_q && CLK_EN
      |=> STATUS_CHANGE_PIN_N) else $error("status pin not gated"); // [RQ11]
   chk_irq_masked: assert property (rd_act && CLK_EN && CORE_IRQ_MASK
      && HOST_ADDR == 11'h202 |=> !HOST_DOUT[1])
      else $error("pending shown while masked"); // [RQ17]
   chk_level_irq: assert property (level_irq_select_q && io_mode
      && irq_pending && CLK_EN |=> !INTERRUPT_REQUEST_N)
      else $error("level interrupt missing"); // [RQ4]
   chk_latch_sets: assert property (
      ready_pin_state != ready_prev_q && CLK_EN |=> ready_change_latch_q)
      else $error("ready change not latched"); // [RQ18]
   chk_ready_read: assert property (rd_act && CLK_EN
      && HOST_ADDR == 11'h204 |=> HOST_DOUT[1] == $past(READY_PIN)
      && HOST_DOUT[3:2] == 2'h3) else $error("pin register wrong"); // [RQ19]

   cov_soft_reset: cover property (wr_stb && HOST_DIN[7]
      && HOST_ADDR == 11'h200);
   cov_primary_hit: cover property (TF_HIT && mode_q == 6'h02);
   cov_status_pin: cover property (!STATUS_CHANGE_PIN_N);
   cov_sleep: cover property (SLEEP_REQ && READY_PIN);
endmodule : ccr_card_config

// File: tb/ccr_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host socket side: attribute cycles, one at a time
// ----------------------------------------------------------------
module ccr_host_model (
   input wire logic clk,
   input wire logic [7:0] dout,
   input wire logic doe,
   output logic reg_n,
   output logic ce1_n,
   output logic oe_n,
   output logic we_n,
   output logic [10:0] addr,
   output logic [7:0] din
);
   // Read strobe idles high, so the card straps to IDE only when the test drives it low
   initial begin
      {reg_n, ce1_n, oe_n, we_n} = 4'hf;
      addr = 11'h000;
      din = 8'h00;
   end
   // Write strobe low for one edge, then high for a cycle
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(posedge clk);
      {reg_n, ce1_n, we_n} <= 3'h0;
      addr <= a;
      din <= d;
      @(posedge clk);
      {reg_n, ce1_n, we_n} <= 3'h7;
      din <= ~d; // Released data must not look valid
      @(posedge clk);
   endtask : wr
   // Strobe held until data enable is sampled, bounded wait
   task automatic rd(input logic [10:0] a, output logic [7:0] d);
      @(posedge clk);
      {reg_n, ce1_n, oe_n} <= 3'h0;
      addr <= a;
      repeat (8) begin
         @(posedge clk);
         if (doe === 1'b1) break;
      end
      d = dout;
      {reg_n, ce1_n, oe_n} <= 3'h7;
   endtask : rd
endmodule : ccr_host_model

// File: tb/tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Register-level checks of the card configuration block
// ----------------------------------------------------------------
module tb;
   logic clk, rst_n, hrst, irq, msk, rdy, idle, cmd, slp_in, rg, ce, oe, we;
   logic doe, crst, io8, slp, rpin, chg_n, irq_n, io, hit, ide, lvl;
   logic [10:0] addr;
   logic [7:0] din, dout, v;
   ccr_pkg::ccr_mode_t mode;
   int n_errors = 0;
   int tests_run = 0;
   // Short counts keep the idle and pulse timers quick
   ccr_card_config #(.IDLE_CYCLES(8), .PULSE_CYCLES(4)) uut (
      .CLK_SYS(clk), .RST_N(rst_n), .CLK_EN(1'b1), .HARD_RESET(hrst),
      .HOST_REG_N(rg), .HOST_CE1_N(ce), .HOST_OE_N(oe), .HOST_WE_N(we),
      .HOST_IO_SEL(io), .HOST_ADDR(addr), .HOST_DIN(din),
      .HOST_DOUT(dout), .HOST_DOE(doe), .CORE_IRQ(irq),
      .CORE_IRQ_MASK(msk), .CORE_READY(rdy), .CORE_IDLE(idle),
      .CORE_CMD(cmd), .CORE_ASLEEP(slp_in), .CARD_RESET(crst),
      .TRUE_IDE(ide), .MODE_INDEX(mode), .LEVEL_IRQ(lvl), .IO_8BIT(io8),
      .SLEEP_REQ(slp), .TF_HIT(hit), .READY_PIN(rpin),
      .STATUS_CHANGE_PIN_N(chg_n), .INTERRUPT_REQUEST_N(irq_n));
   ccr_host_model host (.clk(clk), .dout(dout), .doe(doe), .reg_n(rg),
      .ce1_n(ce), .oe_n(oe), .we_n(we), .addr(addr), .din(din));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic chk(input string nm, input logic [7:0] s, e);
      tests_run++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic rchk(input logic [10:0] a, input logic [7:0] e);
      host.rd(a, v);
      chk("reg", v, e);
   endtask : rchk
   task automatic final_report;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report
   // Whole run is a few hundred cycles; this cuts a hang short
   initial begin
      #100000;
      n_errors++;
      final_report();
   end
   // Main sequence
   initial begin
      {rst_n, hrst, irq, msk, rdy, idle, cmd, slp_in, io} = 9'h000;
      cyc(2);
      rst_n <= 1'b1;
      cyc(2);
      rchk(11'h200, 8'h00);
      rchk(11'h202, 8'h00);
      rchk(11'h204, 8'h0c);
      rchk(11'h206, 8'h00);
      for (int m = 0; m < 4; m++) begin
         host.wr(11'h200, 8'(m));
         cyc(2);
         chk("mode", mode, 8'(m));
         // I/O cycles at one primary and one secondary address
         io <= 1'b1;
         host.rd(11'h1f7, v);
         chk("hit", hit, 8'(m == 1 || m == 2));
         host.rd(11'h177, v);
         chk("hit", hit, 8'(m == 1 || m == 3));
         io <= 1'b0;
      end
      rdy <= 1'b1;
      cyc(4);
      rchk(11'h204, 8'h2e);
      rchk(11'h202, 8'h80);
      host.wr(11'h202, 8'h60);
      host.wr(11'h200, 8'h01);
      cyc(3);
      chk("io8", io8, 1);
      chk("chg", chg_n, 0);
      host.wr(11'h202, 8'h00);
      cyc(3);
      chk("chg", chg_n, 1);
      host.wr(11'h204, 8'h00);
      rchk(11'h204, 8'h2e);
      host.wr(11'h204, 8'hd3);
      rchk(11'h204, 8'h0e);
      // Power-down request: busy until the core reports the state
      host.wr(11'h202, 8'h04);
      cyc(3);
      chk("rdy", rpin, 0);
      chk("slp", slp, 1);
      slp_in <= 1'b1;
      cyc(4);
      chk("rdy", rpin, 1);
      rchk(11'h202, 8'h84);
      host.wr(11'h202, 8'h00);
      slp_in <= 1'b0;
      cyc(4);
      chk("slp", slp, 0);
      chk("rdy", rpin, 1);
      irq <= 1'b1;
      cyc(2);
      host.rd(11'h202, v);
      chk("irq", v & 8'h02, 8'h02);
      msk <= 1'b1;
      cyc(2);
      host.rd(11'h202, v);
      chk("irq", v & 8'h02, 8'h00);
      msk <= 1'b0;
      host.wr(11'h200, 8'h41);
      cyc(3);
      chk("irqn", irq_n, 0);
      chk("lvl", lvl, 1);
      irq <= 1'b0;
      cyc(3);
      chk("irqn", irq_n, 1);
      host.wr(11'h200, 8'h01);
      irq <= 1'b1;
      cyc(4);
      chk("irqn", irq_n, 0);
      cyc(8);
      chk("irqn", irq_n, 1);
      irq <= 1'b0;
      // Soft reset, then hard reset
      host.wr(11'h200, 8'h83);
      cyc(2);
      chk("crst", crst, 1);
      chk("mode", mode, 0);
      rchk(11'h200, 8'h80);
      rchk(11'h202, 8'h00);
      host.wr(11'h200, 8'h00);
      cyc(2);
      chk("crst", crst, 0);
      host.wr(11'h200, 8'h43);
      hrst <= 1'b1;
      cyc(1);
      hrst <= 1'b0;
      cyc(3);
      rchk(11'h200, 8'h00);
      idle <= 1'b1;
      cyc(12);
      chk("slp", slp, 1);
      {idle, cmd} <= 2'b01;
      cyc(1);
      cmd <= 1'b0;
      cyc(3);
      chk("slp", slp, 0);
      // Second reset with the read strobe low straps IDE mode
      rst_n <= 1'b0;
      host.oe_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      cyc(3);
      host.oe_n <= 1'b1;
      chk("ide", ide, 1);
      host.wr(11'h200, 8'h41);
      rchk(11'h200, 8'h00);
      final_report();
   end
endmodule : tb
